// ### charger_status_flag_bank.sv
// Read-only status and flag register bank of a switched-capacitor charger.
// Assumes status and protection inputs are asynchronous; reads come on i_clk.
//
// Overview of operation
// - Input overvoltage in status bits seven, six
// - Output, inputs, bus presence in bits 5-2
// - Input FET pair fitted in bits 1, 0
// - ADC done reads one; zero when continuous
// - Soft-start timeout state in bit six
// - Thermal reading within 5% sets alarm
// - Connector and battery temperature faults shown
// - Die fault and die alarm shown
// - Watchdog expiry shown in bit zero
// - Regulator good and converter running shown
// - Bus error-high shown; reserved bits zero
// - Protection flags set on status change
// - Bank read-only except the interrupt mask, zero after reset
// - Unmasked flags drive the interrupt output
`timescale 1ns/1ns
`include "status_bank_defs.svh"

module charger_status_flag_bank
  import status_bank_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire reg_rd_s      i_rd,
  input  wire logic [7:0]   i_wr_data,
  input  wire logic         i_wr,
  input  wire live_status_s i_status,
  input  wire thermal_s     i_thermal,
  input  wire logic [7:0]   i_prot_status,
  output logic [7:0]        o_rd_data,
  output logic              o_rd_valid,
  output logic              o_int_n
);

  localparam int NSTAT = $bits(live_status_s);

  logic [NSTAT-1:0] st_s1_r, st_s2_r, st_s3_r, st_r;
  logic [7:0]       pr_s1_r, pr_s2_r, pr_s3_r, pr_r, pr_prev_r;
  logic [7:0]       flags_r, mask_r, stat3_r, stat4_r, stat5_r;
  logic             ts_alarm_r;
  logic [7:0]       stat3_nxt, stat4_nxt, stat5_nxt, flags_nxt, rd_nxt;
  live_status_s     s;

  function automatic logic near_thresh(input logic [15:0] rdg, input logic [15:0] thr);
    logic [23:0] lhs;
    logic [23:0] rhs;
    lhs = 24'(rdg) * 24'(`TS_ALARM_PCT_FULL);
    rhs = 24'(thr) * 24'(`TS_ALARM_PCT_FULL - `TS_ALARM_MARGIN_PCT);
    return lhs >= rhs;
  endfunction

  // Three-stage synchronisers; change counts when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < NSTAT; g++) begin : g_st
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          st_s1_r[g] <= 1'b0;
          st_s2_r[g] <= 1'b0;
          st_s3_r[g] <= 1'b0;
          st_r[g]    <= 1'b0;
        end else begin
          st_s1_r[g] <= i_status[g];
          st_s2_r[g] <= st_s1_r[g];
          st_s3_r[g] <= st_s2_r[g];
          if (st_s2_r[g] == st_s3_r[g]) begin
            st_r[g] <= st_s3_r[g];
          end
        end
      end
    end
    for (g = 0; g < 8; g++) begin : g_pr
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          pr_s1_r[g] <= 1'b0;
          pr_s2_r[g] <= 1'b0;
          pr_s3_r[g] <= 1'b0;
          pr_r[g]    <= 1'b0;
        end else begin
          pr_s1_r[g] <= i_prot_status[g];
          pr_s2_r[g] <= pr_s1_r[g];
          pr_s3_r[g] <= pr_s2_r[g];
          if (pr_s2_r[g] == pr_s3_r[g]) begin
            pr_r[g] <= pr_s3_r[g];
          end
        end
      end
    end
  endgenerate

  // Thermal margin comparison, registered to shorten the path
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ts_alarm_r <= 1'b0;
    end else begin
      ts_alarm_r <= near_thresh(i_thermal.conn_reading, i_thermal.conn_thresh) |
                    near_thresh(i_thermal.bat_reading, i_thermal.bat_thresh);
    end
  end

  always_comb begin
    s         = live_status_s'(st_r);
    stat3_nxt = {s.in1_ovp, s.in2_ovp,
                 s.out_present, s.in1_present, s.in2_present, s.bus_present,
                 s.in1_fet, s.in2_fet};
    stat4_nxt = {s.adc_done & ~s.adc_continuous,
                 s.ss_timeout,
                 ts_alarm_r,
                 s.conn_flt, s.bat_flt,
                 s.die_flt, s.die_alm,
                 s.wd_expired};
    stat5_nxt = {s.regn_good, s.conv_run, 1'b0, s.bus_errhi, 4'h0} &
                `REG_CONV_RSVD_MASK;
  end

  // Live status registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stat3_r <= `REG_RESET_VAL;
      stat4_r <= `REG_RESET_VAL;
      stat5_r <= `REG_RESET_VAL;
    end else begin
      stat3_r <= stat3_nxt;
      stat4_r <= stat4_nxt;
      stat5_r <= stat5_nxt;
    end
  end

  // Change flags: set on any edge, cleared by a read; a new edge wins
  always_comb begin
    flags_nxt = flags_r;
    if (i_rd.rd && i_rd.addr == `ADDR_PROT_FLAGS) begin
      flags_nxt = `REG_RESET_VAL;
    end
    flags_nxt = flags_nxt | (pr_r ^ pr_prev_r);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pr_prev_r <= `REG_RESET_VAL;
      flags_r   <= `REG_RESET_VAL;
    end else begin
      pr_prev_r <= pr_r;
      flags_r   <= flags_nxt;
    end
  end

  // Interrupt mask, the only writable location
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mask_r <= `REG_RESET_VAL;
    end else if (i_wr && i_rd.addr == `ADDR_PROT_MASK) begin
      mask_r <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_int_n <= 1'b1;
    end else begin
      o_int_n <= ~|(flags_r & ~mask_r);
    end
  end

  // Read port; writes to status and flag offsets are ignored
  always_comb begin
    unique case (i_rd.addr)
      `ADDR_INPUT_PRESENCE: rd_nxt = stat3_r;
      `ADDR_ADC_THERMAL_WD: rd_nxt = stat4_r;
      `ADDR_REG_CONV:       rd_nxt = stat5_r;
      `ADDR_PROT_FLAGS:     rd_nxt = flags_r;
      `ADDR_PROT_MASK:      rd_nxt = mask_r;
      default:              rd_nxt = `UNMAPPED_READ_VAL;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_data  <= `REG_RESET_VAL;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd.rd;
      if (i_rd.rd) begin
        o_rd_data <= rd_nxt;
      end
    end
  end

  // Checks
  rsvd_bits_zero_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (stat5_r & ~`REG_CONV_RSVD_MASK) == 8'h00) else $error("reserved status bits set");
  adc_cont_zero_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    s.adc_continuous |=> !stat4_r[7]) else $error("adc done set in continuous mode");
  ovp_follow_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ##1 stat3_r[7:6] == $past({s.in1_ovp, s.in2_ovp})) else $error("overvoltage bits wrong");
  present_follow_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ##1 stat3_r[5:2] == $past({s.out_present, s.in1_present, s.in2_present, s.bus_present}))
    else $error("presence bits wrong");
  fet_follow_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ##1 stat3_r[1:0] == $past({s.in1_fet, s.in2_fet})) else $error("fet bits wrong");
  thermal_bits_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ##1 stat4_r[6:0] == $past({s.ss_timeout, ts_alarm_r, s.conn_flt, s.bat_flt,
                               s.die_flt, s.die_alm, s.wd_expired})) else $error("stat4 bits wrong");
  conv_bits_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ##1 stat5_r[7:6] == $past({s.regn_good, s.conv_run})) else $error("stat5 bits wrong");
  flag_set_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (pr_r != pr_prev_r) |=> ((flags_r & $past(pr_r ^ pr_prev_r)) == $past(pr_r ^ pr_prev_r)))
    else $error("flag not set on change");
  flag_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !(i_rd.rd && i_rd.addr == `ADDR_PROT_FLAGS) |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("flag lost without read");
  int_mask_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    |(flags_r & ~mask_r) |=> !o_int_n) else $error("interrupt not raised");
  ro_status_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_wr && i_rd.addr == `ADDR_PROT_FLAGS && pr_r == pr_prev_r && !i_rd.rd) |=> $stable(flags_r))
    else $error("flag register written");
  read_data_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_rd.rd && i_rd.addr == `ADDR_ADC_THERMAL_WD) |=> o_rd_valid && o_rd_data == $past(stat4_r))
    else $error("read data wrong");

  flag_read_c: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    (flags_r != 8'h00) ##1 (i_rd.rd && i_rd.addr == `ADDR_PROT_FLAGS));
  set_during_clr_c: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    i_rd.rd && i_rd.addr == `ADDR_PROT_FLAGS && (pr_r != pr_prev_r));
  int_fire_c: cover property (@(posedge i_clk) disable iff (!i_reset_n) $fell(o_int_n));
endmodule

// ### status_bank_defs.svh
// Offsets, field positions and reset values of the charger status and flag bank.
// Assumes inclusion by bare name from the design file.
`ifndef STATUS_BANK_DEFS_SVH
`define STATUS_BANK_DEFS_SVH

`define ADDR_INPUT_PRESENCE     8'h15
`define ADDR_ADC_THERMAL_WD     8'h16
`define ADDR_REG_CONV           8'h17
`define ADDR_PROT_FLAGS         8'h18
`define ADDR_PROT_MASK          8'h1d
`define REG_RESET_VAL           8'h00
`define UNMAPPED_READ_VAL       8'h00
`define SYNC_RESET_VAL          3'h0
`define TS_ALARM_MARGIN_PCT     5
`define TS_ALARM_PCT_FULL       100
`define REG_CONV_RSVD_MASK      8'hd0

`endif

// ### status_bank_pkg.sv
// Types for the charger status and flag bank.
// Assumes the constants header sits in the same folder.
package status_bank_pkg;
  // Register read request from the serial interface
  typedef struct packed {
    logic       rd;
    logic [7:0] addr;
  } reg_rd_s;

  // Live status inputs from the analog front end
  typedef struct packed {
    logic       in1_ovp;
    logic       in2_ovp;
    logic       out_present;
    logic       in1_present;
    logic       in2_present;
    logic       bus_present;
    logic       in1_fet;
    logic       in2_fet;
    logic       adc_done;
    logic       adc_continuous;
    logic       ss_timeout;
    logic       conn_flt;
    logic       bat_flt;
    logic       die_flt;
    logic       die_alm;
    logic       wd_expired;
    logic       regn_good;
    logic       conv_run;
    logic       bus_errhi;
  } live_status_s;

  // Thermal sensor readings and fault thresholds
  typedef struct packed {
    logic [15:0] conn_reading;
    logic [15:0] conn_thresh;
    logic [15:0] bat_reading;
    logic [15:0] bat_thresh;
  } thermal_s;
endpackage

// ### host_model.sv
// Host model that reads and writes the status bank registers.
// Assumes the bank answers a read within three clock cycles.
`timescale 1ns/1ns
module host_model
  import status_bank_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  output reg_rd_s         o_rd,
  output logic [7:0]      o_wr_data,
  output logic            o_wr
);
  initial begin
    o_rd = '0;
    o_wr_data = 8'h00;
    o_wr = 1'b0;
  end

  // One read strobe, then a bounded wait for the answer
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    int n;
    @(negedge i_clk);
    o_rd = '{rd: 1'b1, addr: a};
    @(negedge i_clk);
    o_rd.rd = 1'b0;
    for (n = 0; n < 3 && i_rd_valid !== 1'b1; n++) begin
      @(negedge i_clk);
    end
    ok = (i_rd_valid === 1'b1);
    d = i_rd_data;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_rd.addr = a;
    o_wr_data = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
  endtask
endmodule

// ### tb.sv
// Self-checking bench of the charger status and flag bank.
// Assumes the host model drives reads; inputs change on falling edges.
`timescale 1ns/1ns
module tb
  import status_bank_pkg::*;
;
  logic         clk;
  logic         rst_n;
  reg_rd_s      rd;
  logic [7:0]   wr_data;
  logic         wr;
  live_status_s status;
  thermal_s     thermal;
  logic [7:0]   prot;
  logic [7:0]   rd_data;
  logic         rd_valid;
  logic         int_n;
  int           miscompares = 0;
  int           n_compared = 0;

  charger_status_flag_bank u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_rd(rd), .i_wr_data(wr_data),
    .i_wr(wr), .i_status(status), .i_thermal(thermal), .i_prot_status(prot),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_int_n(int_n));
  host_model u_host (.i_clk(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
    .o_rd(rd), .o_wr_data(wr_data), .o_wr(wr));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic close_out();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    bit         ok;
    u_host.rd(a, d, ok);
    n_compared++;
    if (!ok || d !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t addr %h got %h exp %h", $time, a, d, e);
    end
  endtask

  task automatic chk_int(input logic e);
    n_compared++;
    if (int_n !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t interrupt %b exp %b", $time, int_n, e);
    end
  endtask

  task automatic put(input logic [18:0] v);
    @(negedge clk);
    status = v;
    repeat (6) @(negedge clk);
  endtask

  task automatic t_reset_ro();
    chk(8'h15, 8'h00);
    chk(8'h16, 8'h00);
    chk(8'h17, 8'h00);
    chk(8'h18, 8'h00);
    chk(8'h20, 8'h00);
    u_host.wr(8'h15, 8'hff);
    chk(8'h15, 8'h00);
    u_host.wr(8'h18, 8'hff);
    chk(8'h18, 8'h00);
    chk_int(1'b1);
    $display("test reset_ro done");
  endtask

  task automatic t_stat();
    logic [18:0] src [13] = '{19'h800, 19'h400, 19'h600, 19'h100, 19'h080, 19'h040, 19'h020,
                              19'h010, 19'h008, 19'h004, 19'h002, 19'h001, 19'h7ffff};
    logic [7:0]  adr [13] = '{8'h15, 8'h16, 8'h16, 8'h16, 8'h16, 8'h16, 8'h16,
                              8'h16, 8'h16, 8'h17, 8'h17, 8'h17, 8'h17};
    logic [7:0]  exp [13] = '{8'h01, 8'h80, 8'h00, 8'h40, 8'h10, 8'h08, 8'h04,
                              8'h02, 8'h01, 8'h80, 8'h40, 8'h10, 8'hd0};
    for (int i = 0; i < 8; i++) begin
      put(19'h800 << i);
      chk(8'h15, 8'h01 << i);
    end
    for (int i = 0; i < 13; i++) begin
      put(src[i]);
      chk(adr[i], exp[i]);
    end
    chk(8'h16, 8'h5f);
    put(19'h0);
    $display("test stat done");
  endtask

  task automatic thm(input logic [15:0] c, input logic [15:0] b, input logic [7:0] e);
    @(negedge clk);
    thermal.conn_reading = c;
    thermal.bat_reading = b;
    repeat (4) @(negedge clk);
    chk(8'h16, e);
  endtask

  task automatic t_thermal();
    thm(16'h5e, 16'h00, 8'h00);
    thm(16'h5f, 16'h00, 8'h20);
    thm(16'h00, 16'h5f, 8'h20);
    thm(16'h00, 16'h5e, 8'h00);
    $display("test thermal done");
  endtask

  task automatic t_flags();
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      prot[i] = 1'b1;
      repeat (6) @(negedge clk);
      chk_int(1'b0);
      chk(8'h18, 8'h01 << i);
      chk(8'h18, 8'h00);
      chk_int(1'b1);
      prot[i] = 1'b0;
      repeat (6) @(negedge clk);
      chk(8'h18, 8'h01 << i);
      chk(8'h18, 8'h00);
    end
    u_host.wr(8'h1d, 8'h80);
    prot[7] = 1'b1;
    repeat (6) @(negedge clk);
    chk_int(1'b1);
    chk(8'h18, 8'h80);
    prot[6] = 1'b1;
    repeat (6) @(negedge clk);
    chk_int(1'b0);
    chk(8'h18, 8'h40);
    @(negedge clk);
    prot[0] = 1'b1;
    repeat (3) @(negedge clk);
    chk(8'h18, 8'h00);
    chk(8'h18, 8'h01);
    $display("test flags done");
  endtask

  task automatic t_mid_reset();
    put(19'h7ffff);
    @(negedge clk);
    prot = 8'h00;
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk(8'h15, 8'h00);
    chk(8'h1d, 8'h00);
    chk_int(1'b1);
    chk(8'h17, 8'hd0);
    $display("test mid_reset done");
  endtask

  initial begin
    rst_n = 1'b0;
    status = '0;
    thermal = {16'h0, 16'h64, 16'h0, 16'h64};
    prot = 8'h00;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_reset_ro();
    t_stat();
    t_thermal();
    t_flags();
    t_mid_reset();
    close_out();
  end

  initial begin
    #5000000;
    miscompares++;
    $display("CHECK FAILED t=%0t run timed out", $time);
    close_out();
  end
endmodule
